// *** tdm_align_pkg.sv ***
// constants and types shared by the input delay alignment block
// assumes one core clock; register offsets are the word addresses seen on the processor port
package tdm_align_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int STREAMS_PER_PORT = 16;
	localparam int ALL_STREAMS      = 32;
	localparam int ADDR_W           = 14;
	localparam int DATA_W           = 16;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [13:0] LOCAL_IN_CHANNEL_DELAY_BASE     = 14'h0003;
	localparam logic [13:0] LOCAL_IN_BIT_DELAY_BASE         = 14'h0023;
	localparam logic [13:0] BACKPLANE_IN_CHANNEL_DELAY_BASE = 14'h0043;
	localparam logic [13:0] BACKPLANE_IN_BIT_DELAY_BASE     = 14'h0063;
	localparam logic [13:0] REGS_PER_BANK                   = 14'h0010;

	// ----------------------------------------------------------------
	// field layout and reset values
	// ----------------------------------------------------------------
	localparam int          CHAN_FIELD_W      = 8;
	localparam int          CHAN_FIELD_LSB    = 0;
	localparam int          BIT_FIELD_W       = 5;
	localparam int          BIT_FIELD_LSB     = 0;
	localparam logic [7:0]  CHAN_DELAY_RESET  = 8'h00;
	localparam logic [4:0]  BIT_DELAY_RESET   = 5'h00;
	localparam logic [15:0] READ_ZERO         = 16'h0000;

	// ----------------------------------------------------------------
	// stream timing
	// ----------------------------------------------------------------
	localparam logic [1:0] RATE_2M            = 2'h0;
	localparam logic [1:0] RATE_4M            = 2'h1;
	localparam logic [1:0] RATE_8M            = 2'h2;
	localparam logic [1:0] RATE_16M           = 2'h3;
	localparam logic [7:0] LAST_CHAN_2M       = 8'h1f;
	localparam logic [7:0] LAST_CHAN_4M       = 8'h3f;
	localparam logic [7:0] LAST_CHAN_8M       = 8'h7f;
	localparam logic [7:0] LAST_CHAN_16M      = 8'hff;
	localparam logic [1:0] LAST_QUARTER       = 2'h3;
	localparam logic [2:0] LAST_BIT_OF_CHAN   = 3'h7;

	typedef enum logic [1:0] {
		BANK_LOCAL_CHAN,
		BANK_LOCAL_BIT,
		BANK_BACK_CHAN,
		BANK_BACK_BIT
	} bank_type;

endpackage

// *** delay_reg_store.sv ***
// delay register storage for all 32 input streams
// assumes the caller decodes the address; read data appear one clock after rd_en_i
`timescale 1ns/1ps

module delay_reg_store
	import tdm_align_pkg::*;
(
	// clock and reset
	input  wire logic                                core_clk_i,
	input  wire logic                                rst_n_i,
	input  wire logic                                ce_i,
	// access port
	input  wire logic                                wr_en_i,
	input  wire logic                                rd_en_i,
	input  wire bank_type                            bank_i,
	input  wire logic [3:0]                          idx_i,
	input  wire logic [DATA_W-1:0]                   wdata_i,
	output logic      [DATA_W-1:0]                   rdata_o,
	// fields, stream s at slice s; 0-15 local, 16-31 backplane
	output logic      [ALL_STREAMS*CHAN_FIELD_W-1:0] chan_delay_o,
	output logic      [ALL_STREAMS*BIT_FIELD_W-1:0]  bit_delay_o
);

	logic [CHAN_FIELD_W-1:0] chan_mem [ALL_STREAMS];
	logic [BIT_FIELD_W-1:0]  bit_mem  [ALL_STREAMS];
	logic [4:0]              slot;
	logic                    is_chan;

	assign slot    = {(bank_i == BANK_BACK_CHAN) || (bank_i == BANK_BACK_BIT), idx_i};
	assign is_chan = (bank_i == BANK_LOCAL_CHAN) || (bank_i == BANK_BACK_CHAN);

	// ----------------------------------------------------------------
	// write side; reserved bits are simply not stored
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < ALL_STREAMS; i++) begin
				chan_mem[i] <= CHAN_DELAY_RESET;
				bit_mem[i]  <= BIT_DELAY_RESET;
			end
		end else if (ce_i && wr_en_i) begin
			if (is_chan) begin
				chan_mem[slot] <= wdata_i[CHAN_FIELD_LSB +: CHAN_FIELD_W];
			end else begin
				bit_mem[slot] <= wdata_i[BIT_FIELD_LSB +: BIT_FIELD_W];
			end
		end
	end

	// ----------------------------------------------------------------
	// registered read, reserved bits zero
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rdata_o <= READ_ZERO;
		end else if (ce_i && rd_en_i) begin
			if (is_chan) begin
				rdata_o <= {{(DATA_W-CHAN_FIELD_W){1'b0}}, chan_mem[slot]};
			end else begin
				rdata_o <= {{(DATA_W-BIT_FIELD_W){1'b0}}, bit_mem[slot]};
			end
		end
	end

	always_comb begin
		for (int i = 0; i < ALL_STREAMS; i++) begin
			chan_delay_o[i*CHAN_FIELD_W +: CHAN_FIELD_W] = chan_mem[i];
			bit_delay_o[i*BIT_FIELD_W +: BIT_FIELD_W]    = bit_mem[i];
		end
	end

endmodule

// *** tdm_input_delay_align.sv ***
// per-stream input channel and bit delay alignment, local and backplane ports
// assumes a quarter-bit tick per rate from the clock generator and one frame pulse per port
// assumes software keeps each channel delay inside its stream's channel range
`timescale 1ns/1ps

module tdm_input_delay_align
	import tdm_align_pkg::*;
(
	// clock, reset, enable
	input  wire logic                                    core_clk_i,
	input  wire logic                                    rst_n_i,
	input  wire logic                                    ce_i,
	// processor port
	input  wire logic                                    cs_n_i,
	input  wire logic                                    ds_n_i,
	input  wire logic                                    rw_i,
	input  wire logic [ADDR_W-1:0]                       addr_i,
	input  wire logic [DATA_W-1:0]                       data_i,
	output logic      [DATA_W-1:0]                       data_o,
	output logic                                         data_oe_o,
	output logic                                         dtack_n_o,
	// timing
	input  wire logic [3:0]                              qtick_i,
	input  wire logic                                    local_frame_i,
	input  wire logic                                    backplane_frame_i,
	input  wire logic [STREAMS_PER_PORT*2-1:0]           local_rate_i,
	input  wire logic [STREAMS_PER_PORT*2-1:0]           backplane_rate_i,
	// serial inputs
	input  wire logic [STREAMS_PER_PORT-1:0]             local_serial_in_i,
	input  wire logic [STREAMS_PER_PORT-1:0]             backplane_serial_in_i,
	// aligned local channels
	output wire logic [STREAMS_PER_PORT-1:0]             local_chan_valid_o,
	output wire logic [STREAMS_PER_PORT*8-1:0]           local_chan_num_o,
	output wire logic [STREAMS_PER_PORT*8-1:0]           local_chan_data_o,
	// aligned backplane channels
	output wire logic [STREAMS_PER_PORT-1:0]             backplane_chan_valid_o,
	output wire logic [STREAMS_PER_PORT*8-1:0]           backplane_chan_num_o,
	output wire logic [STREAMS_PER_PORT*8-1:0]           backplane_chan_data_o
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic in_bank(input logic [ADDR_W-1:0] a, input logic [13:0] base);
		in_bank = (a >= base) && (a < base + REGS_PER_BANK);
	endfunction

	function automatic logic [7:0] last_chan(input logic [1:0] rate);
		case (rate)
			RATE_2M:  last_chan = LAST_CHAN_2M;
			RATE_4M:  last_chan = LAST_CHAN_4M;
			RATE_8M:  last_chan = LAST_CHAN_8M;
			default:  last_chan = LAST_CHAN_16M;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	logic        addr_hit;
	bank_type    addr_bank;
	logic [13:0] addr_base;
	logic [13:0] addr_off;

	// the banks never overlap, so the first hit decides
	always_comb begin
		addr_hit  = 1'b1;
		addr_bank = BANK_LOCAL_CHAN;
		addr_base = LOCAL_IN_CHANNEL_DELAY_BASE;
		if (in_bank(addr_i, LOCAL_IN_CHANNEL_DELAY_BASE)) begin
			addr_bank = BANK_LOCAL_CHAN;
			addr_base = LOCAL_IN_CHANNEL_DELAY_BASE;
		end else if (in_bank(addr_i, LOCAL_IN_BIT_DELAY_BASE)) begin
			addr_bank = BANK_LOCAL_BIT;
			addr_base = LOCAL_IN_BIT_DELAY_BASE;
		end else if (in_bank(addr_i, BACKPLANE_IN_CHANNEL_DELAY_BASE)) begin
			addr_bank = BANK_BACK_CHAN;
			addr_base = BACKPLANE_IN_CHANNEL_DELAY_BASE;
		end else if (in_bank(addr_i, BACKPLANE_IN_BIT_DELAY_BASE)) begin
			addr_bank = BANK_BACK_BIT;
			addr_base = BACKPLANE_IN_BIT_DELAY_BASE;
		end else begin
			addr_hit = 1'b0;
		end
		addr_off = addr_i - addr_base;
	end

	// ----------------------------------------------------------------
	// processor port handshake
	// ----------------------------------------------------------------
	// reads take one extra cycle because the store answers from its own register
	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_READ,
		BUS_ACK
	} bus_state_type;

	bus_state_type     bus_state;
	logic              strobe;
	logic              mem_wr;
	logic              mem_rd;
	logic              read_hit;
	logic [DATA_W-1:0] mem_rdata;
	logic [ALL_STREAMS*CHAN_FIELD_W-1:0] chan_delay;
	logic [ALL_STREAMS*BIT_FIELD_W-1:0]  bit_delay;

	assign strobe = !cs_n_i && !ds_n_i;
	// unmapped writes are acknowledged but dropped
	assign mem_wr = (bus_state == BUS_IDLE) && strobe && !rw_i && addr_hit;
	assign mem_rd = (bus_state == BUS_IDLE) && strobe && rw_i;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			bus_state <= BUS_IDLE;
			data_o    <= READ_ZERO;
			data_oe_o <= 1'b0;
			dtack_n_o <= 1'b1;
			read_hit  <= 1'b0;
		end else if (ce_i) begin
			// with ce_i low the handshake stalls too; a waiting master simply waits longer
			case (bus_state)
				BUS_IDLE: begin
					if (strobe && rw_i) begin
						read_hit  <= addr_hit;
						bus_state <= BUS_READ;
					end else if (strobe) begin
						dtack_n_o <= 1'b0;
						bus_state <= BUS_ACK;
					end
				end
				BUS_READ: begin
					data_o    <= read_hit ? mem_rdata : READ_ZERO;
					data_oe_o <= 1'b1;
					dtack_n_o <= 1'b0;
					bus_state <= BUS_ACK;
				end
				BUS_ACK: begin
					// hold the answer until the master drops its strobe
					if (!strobe) begin
						dtack_n_o <= 1'b1;
						data_oe_o <= 1'b0;
						bus_state <= BUS_IDLE;
					end
				end
				default: begin
					bus_state <= BUS_IDLE;
				end
			endcase
		end
	end

	// writes land on the taking edge, so the ack never runs ahead of the stored value
	delay_reg_store u_store (
		.core_clk_i   (core_clk_i),
		.rst_n_i      (rst_n_i),
		.ce_i         (ce_i),
		.wr_en_i      (mem_wr),
		.rd_en_i      (mem_rd),
		.bank_i       (addr_bank),
		.idx_i        (addr_off[3:0]),
		.wdata_i      (data_i),
		.rdata_o      (mem_rdata),
		.chan_delay_o (chan_delay),
		.bit_delay_o  (bit_delay)
	);

	// ----------------------------------------------------------------
	// per-stream receivers, streams 0-15 local, 16-31 backplane
	// ----------------------------------------------------------------
	logic [ALL_STREAMS-1:0]   all_valid;
	logic [ALL_STREAMS*8-1:0] all_num;
	logic [ALL_STREAMS*8-1:0] all_data;

	genvar s;
	generate
		for (s = 0; s < ALL_STREAMS; s++) begin : g_rx
			localparam int P = s % STREAMS_PER_PORT;
			logic [1:0] rate;
			logic       frame;
			logic       serial;
			logic       tick;
			logic [7:0] cdly;
			logic [4:0] bdly;
			logic       armed;
			logic       running;
			logic [4:0] wait_cnt;
			logic [1:0] quarter;
			logic [2:0] bit_cnt;
			logic [7:0] shift;
			logic [7:0] rx_chan;
			logic       sample;
			logic [7:0] next_shift;
			logic       valid;
			logic [7:0] num;
			logic [7:0] data;

			// ------------------------------------------------
			// stream selection
			// ------------------------------------------------
			if (s < STREAMS_PER_PORT) begin : g_local
				assign rate   = local_rate_i[P*2 +: 2];
				assign frame  = local_frame_i;
				assign serial = local_serial_in_i[P];
			end else begin : g_back
				assign rate   = backplane_rate_i[P*2 +: 2];
				assign frame  = backplane_frame_i;
				assign serial = backplane_serial_in_i[P];
			end

			// ------------------------------------------------
			// delay fields and sampling point
			// ------------------------------------------------
			assign cdly = chan_delay[s*CHAN_FIELD_W +: CHAN_FIELD_W];
			assign bdly = bit_delay[s*BIT_FIELD_W +: BIT_FIELD_W];
			// a slower stream simply sees fewer ticks, so delay scales with its rate
			assign tick = qtick_i[rate];
			// a tick on the frame cycle itself is dropped, so the pulse must fall between ticks
			assign sample = tick && ((armed && wait_cnt == 5'h00) || (running && quarter == LAST_QUARTER));
			assign next_shift = {shift[6:0], serial};

			// ------------------------------------------------
			// sampling phase
			// ------------------------------------------------
			// wait out the delay, then sample once per four ticks
			always_ff @(posedge core_clk_i) begin
				if (!rst_n_i) begin
					armed    <= 1'b0;
					running  <= 1'b0;
					wait_cnt <= BIT_DELAY_RESET;
					quarter  <= 2'h0;
				end else if (ce_i) begin
					// a new pulse restarts the phase and drops any part-built channel
					if (frame) begin
						armed    <= 1'b1;
						running  <= 1'b0;
						wait_cnt <= bdly;
						quarter  <= 2'h0;
					end else if (tick && armed) begin
						if (wait_cnt == 5'h00) begin
							armed   <= 1'b0;
							running <= 1'b1;
						end else begin
							wait_cnt <= wait_cnt - 5'h01;
						end
					end else if (tick && running) begin
						quarter <= quarter + 2'h1;
					end
				end
			end

			// ------------------------------------------------
			// bit assembly and channel numbering
			// ------------------------------------------------
			always_ff @(posedge core_clk_i) begin
				if (!rst_n_i) begin
					bit_cnt <= 3'h0;
					shift   <= 8'h00;
					rx_chan <= 8'h00;
					valid   <= 1'b0;
					num     <= 8'h00;
					data    <= 8'h00;
				end else if (ce_i) begin
					valid <= 1'b0;
					if (frame) begin
						bit_cnt <= 3'h0;
						rx_chan <= 8'h00;
					end else if (sample) begin
						shift   <= next_shift;
						bit_cnt <= bit_cnt + 3'h1;
						if (bit_cnt == LAST_BIT_OF_CHAN) begin
							valid   <= 1'b1;
							data    <= next_shift;
							// channels before the delay wrap to the previous frame's tail
							num     <= (rx_chan - cdly) & last_chan(rate);
							rx_chan <= rx_chan + 8'h01;
						end
					end
				end
			end

			assign all_valid[s]      = valid;
			assign all_num[s*8 +: 8]  = num;
			assign all_data[s*8 +: 8] = data;
		end
	endgenerate

	// ----------------------------------------------------------------
	// outputs, each bit straight from a receiver flop
	// ----------------------------------------------------------------
	assign local_chan_valid_o     = all_valid[STREAMS_PER_PORT-1:0];
	assign local_chan_num_o       = all_num[STREAMS_PER_PORT*8-1:0];
	assign local_chan_data_o      = all_data[STREAMS_PER_PORT*8-1:0];
	assign backplane_chan_valid_o = all_valid[ALL_STREAMS-1:STREAMS_PER_PORT];
	assign backplane_chan_num_o   = all_num[ALL_STREAMS*8-1:STREAMS_PER_PORT*8];
	assign backplane_chan_data_o  = all_data[ALL_STREAMS*8-1:STREAMS_PER_PORT*8];

endmodule

// *** tdm_stream_src.sv ***
// serial stream source standing in for an external tdm device
// assumes one tick per quarter bit at the stream's rate and a one-cycle frame pulse
`timescale 1ns/1ps

module tdm_stream_src (
	// clock and reset
	input  wire logic core_clk_i,
	input  wire logic rst_n_i,
	// timing
	input  wire logic frame_i,
	input  wire logic tick_i,
	// serial line
	output logic      serial_o
);
	// ----------------------------------------------------------------
	// bit sequencer
	// ----------------------------------------------------------------
	logic [14:0] ticks;
	logic [14:0] pos;
	logic [9:0]  chan;
	logic [7:0]  pattern;

	// each bit stands for four ticks, so every quarter-bit sampling point lands inside one bit
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || frame_i) begin
			ticks <= 15'h0000;
		end else if (tick_i) begin
			ticks <= ticks + 15'h0001;
		end
	end

	// bits run half a bit ahead of the frame, so the quarter part of a bit delay decides which bit is caught
	assign pos      = ticks + 15'h0002;
	assign chan     = pos[14:5];
	assign pattern  = {chan[3:0], ~chan[3:0]} ^ 8'h96;
	assign serial_o = pattern[3'h7 - pos[4:2]];
endmodule

// *** tdm_align_checker.sv ***
// concurrent checks on the ports of the input delay alignment block
// assumes bound to the top module, one clock domain
`timescale 1ns/1ps

module tdm_align_checker (
	// clock and reset
	input wire logic         core_clk_i,
	input wire logic         rst_n_i,
	input wire logic         ce_i,
	// processor port
	input wire logic         cs_n_i,
	input wire logic         ds_n_i,
	input wire logic         rw_i,
	input wire logic [15:0]  data_o,
	input wire logic         data_oe_o,
	input wire logic         dtack_n_o,
	// aligned channels
	input wire logic [15:0]  local_chan_valid_o,
	input wire logic [127:0] local_chan_num_o,
	input wire logic [15:0]  backplane_chan_valid_o,
	input wire logic [127:0] backplane_chan_data_o
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	wire strb_n = cs_n_i | ds_n_i;

	default clocking @(posedge core_clk_i); endclocking
	// a frozen clock enable holds the port still, so no timing is owed while it is low
	default disable iff (!rst_n_i || !ce_i);

	sequence s_read_req;
		$fell(strb_n) && rw_i;
	endsequence
	sequence s_read_answer;
		dtack_n_o ##1 (!dtack_n_o && data_oe_o);
	endsequence

	a_write_ack_next: assert property ($fell(strb_n) && !rw_i |=> !dtack_n_o && !data_oe_o)
		else $error("write not acknowledged one cycle after strobe");
	a_read_ack_two: assert property (s_read_req |=> s_read_answer)
		else $error("read answer not two cycles after strobe");
	a_ack_bounded: assert property ($fell(strb_n) |-> ##[1:2] !dtack_n_o)
		else $error("acknowledge late");
	a_oe_with_ack: assert property (data_oe_o |-> !dtack_n_o)
		else $error("data driven without acknowledge");
	a_ack_holds: assert property (!dtack_n_o && !strb_n |=> !dtack_n_o)
		else $error("acknowledge dropped while strobe low");
	a_ack_release: assert property (!dtack_n_o && strb_n |=> dtack_n_o && !data_oe_o)
		else $error("acknowledge kept after strobe release");
	a_read_data_stable: assert property (data_oe_o && $past(data_oe_o) |-> $stable(data_o))
		else $error("read data moved while driven");
	a_local_valid_pulse: assert property ((local_chan_valid_o & $past(local_chan_valid_o)) == 16'h0000)
		else $error("local channel valid longer than one cycle");
	a_local_num_held: assert property ($changed(local_chan_num_o) |-> local_chan_valid_o != 16'h0000)
		else $error("local channel number moved without valid");
	a_bp_data_held: assert property ($changed(backplane_chan_data_o) |-> backplane_chan_valid_o != 16'h0000)
		else $error("backplane channel data moved without valid");
endmodule

bind tdm_input_delay_align tdm_align_checker chk (
	.core_clk_i            (core_clk_i),
	.rst_n_i               (rst_n_i),
	.ce_i                  (ce_i),
	.cs_n_i                (cs_n_i),
	.ds_n_i                (ds_n_i),
	.rw_i                  (rw_i),
	.data_o                (data_o),
	.data_oe_o             (data_oe_o),
	.dtack_n_o             (dtack_n_o),
	.local_chan_valid_o    (local_chan_valid_o),
	.local_chan_num_o      (local_chan_num_o),
	.backplane_chan_valid_o(backplane_chan_valid_o),
	.backplane_chan_data_o (backplane_chan_data_o)
);

// *** tdm_input_delay_align_tb_top.sv ***
// self-checking bench for the input delay alignment block
// assumes the stream source model and the checker are compiled before it
`timescale 1ns/1ps

module tdm_input_delay_align_tb_top import tdm_align_pkg::*;;
	// ----------------------------------------------------------------
	// signals and design
	// ----------------------------------------------------------------
	logic         core_clk_i = 1'b0, rst_n_i = 1'b0, cs_n_i = 1'b1, ds_n_i = 1'b1, rw_i = 1'b1;
	logic         lfrm = 1'b0, bfrm = 1'b0, ce_i = 1'b1;
	logic [13:0]  addr_i = 14'h0000;
	logic [15:0]  data_i = 16'h0000, rd;
	logic [3:0]   qtick_i = 4'h0;
	wire  [15:0]  data_o, lval, bval, lser, bser;
	wire  [127:0] lnum, ldat, bnum, bdat;
	wire          data_oe_o, dtack_n_o;
	int           fail_count = 0, compares = 0, cyc = 0;
	logic [7:0]   cd [2][16];
	logic [4:0]   bd [2][16];
	logic [15:0]  seen [2] = '{16'h0000, 16'h0000};

	always #2.5 core_clk_i = ~core_clk_i;

	tdm_input_delay_align uut (
		.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
		.cs_n_i(cs_n_i), .ds_n_i(ds_n_i), .rw_i(rw_i), .addr_i(addr_i), .data_i(data_i),
		.data_o(data_o), .data_oe_o(data_oe_o), .dtack_n_o(dtack_n_o), .qtick_i(qtick_i),
		.local_frame_i(lfrm), .backplane_frame_i(bfrm),
		.local_rate_i(32'he4e4_e4e4), .backplane_rate_i(32'h1b1b_1b1b),
		.local_serial_in_i(lser), .backplane_serial_in_i(bser),
		.local_chan_valid_o(lval), .local_chan_num_o(lnum), .local_chan_data_o(ldat),
		.backplane_chan_valid_o(bval), .backplane_chan_num_o(bnum), .backplane_chan_data_o(bdat)
	);

	for (genvar n = 0; n < 16; n++) begin : g_src
		tdm_stream_src sl (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .frame_i(lfrm),
			.tick_i(qtick_i[n % 4]), .serial_o(lser[n]));
		tdm_stream_src sb (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .frame_i(bfrm),
			.tick_i(qtick_i[3 - n % 4]), .serial_o(bser[n]));
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic end_of_test();
		if (fail_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(string what, logic [15:0] got, logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// request held until acknowledge is sampled, then released for two edges so the port is idle again
	task automatic bus_rw(input logic rd_en, input logic [13:0] a, input logic [15:0] wd, output logic [15:0] q);
		int k;
		cs_n_i <= 1'b0;
		ds_n_i <= 1'b0;
		rw_i   <= rd_en;
		addr_i <= a;
		data_i <= wd;
		k = 0;
		do begin
			@(posedge core_clk_i);
			k++;
		end while (dtack_n_o !== 1'b0 && k < 20);
		q = data_o;
		cs_n_i <= 1'b1;
		ds_n_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
	endtask

	function automatic logic [7:0] exp_byte(int shift);
		logic [7:0] r, b;
		logic [3:0] k;
		for (int i = 0; i < 8; i++) begin
			k = 4'((shift + i) >> 3);
			b = {k, ~k} ^ 8'h96;
			r[7 - i] = b[7 - (shift + i) % 8];
		end
		return r;
	endfunction

	task automatic stream_check(int p, int n, logic [7:0] num, logic [7:0] dat);
		int r, skip;
		r = p ? 3 - n % 4 : n % 4;
		// the source leads by half a bit, so two quarters of delay already reach the next bit
		skip = (bd[p][n] + 2) >> 2;
		seen[p][n] = 1'b1;
		check("channel number", {8'h00, num}, {8'h00, 8'((0 - cd[p][n]) & ((32 << r) - 1))});
		check("channel data", {8'h00, dat}, {8'h00, exp_byte(skip)});
	endtask

	// ----------------------------------------------------------------
	// ticks, timeout, channel monitor
	// ----------------------------------------------------------------
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		for (int r = 0; r < 4; r++)
			qtick_i[r] <= (cyc % (16 >> r)) == 0;
		if (cyc == 20000) begin
			fail_count++;
			end_of_test();
		end
	end

	always @(posedge core_clk_i)
		if (rst_n_i)
			for (int n = 0; n < 16; n++) begin
				if (lval[n] && !seen[0][n])
					stream_check(0, n, lnum[8*n+:8], ldat[8*n+:8]);
				if (bval[n] && !seen[1][n])
					stream_check(1, n, bnum[8*n+:8], bdat[8*n+:8]);
			end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [13:0] a;
		int r;
		repeat (5) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		@(posedge core_clk_i);
		for (int b = 0; b < 4; b++)
			for (int n = 0; n < 16; n++) begin
				a = LOCAL_IN_CHANNEL_DELAY_BASE + 14'(b * 32 + n);
				bus_rw(1'b1, a, 16'h0000, rd);
				check("reset value", rd, 16'h0000);
				bus_rw(1'b0, a, 16'hffff, rd);
				bus_rw(1'b1, a, 16'h0000, rd);
				check("field width", rd, b[0] ? 16'h001f : 16'h00ff);
			end
		bus_rw(1'b0, 14'h0013, 16'hffff, rd);
		bus_rw(1'b1, 14'h0013, 16'h0000, rd);
		check("unmapped read", rd, 16'h0000);
		for (int n = 0; n < 16; n++) begin
			r = n % 4;
			cd[0][n] = 8'((255 - n * 11) & ((32 << r) - 1));
			bd[0][n] = 5'((n * 19) % 32);
			cd[1][n] = 8'((n * 11) & ((32 << (3 - r)) - 1));
			bd[1][n] = 5'((n * 13) % 32);
			bus_rw(1'b0, LOCAL_IN_CHANNEL_DELAY_BASE + 14'(n), {8'h00, cd[0][n]}, rd);
			bus_rw(1'b0, LOCAL_IN_BIT_DELAY_BASE + 14'(n), {11'h000, bd[0][n]}, rd);
			bus_rw(1'b0, BACKPLANE_IN_CHANNEL_DELAY_BASE + 14'(n), {8'h00, cd[1][n]}, rd);
			bus_rw(1'b0, BACKPLANE_IN_BIT_DELAY_BASE + 14'(n), {11'h000, bd[1][n]}, rd);
		end
		// with the enable low the port must neither answer nor store
		ce_i <= 1'b0;
		bus_rw(1'b0, LOCAL_IN_CHANNEL_DELAY_BASE, 16'h00a5, rd);
		check("frozen ack", {15'h0000, dtack_n_o}, 16'h0001);
		ce_i <= 1'b1;
		bus_rw(1'b1, LOCAL_IN_CHANNEL_DELAY_BASE, 16'h0000, rd);
		check("frozen write", rd, {8'h00, cd[0][0]});
		// frame pulses go on odd cycles, where no tick is ever raised
		while (!cyc[0])
			@(posedge core_clk_i);
		lfrm <= 1'b1;
		bfrm <= 1'b1;
		@(posedge core_clk_i);
		lfrm <= 1'b0;
		bfrm <= 1'b0;
		while (seen[0] !== 16'hffff || seen[1] !== 16'hffff)
			@(posedge core_clk_i);
		end_of_test();
	end
endmodule
